// ==== core/pcsd_pkg.sv ====
// Package for the pulse-count switch decoder: timing constants and states.
// Assumes a 100 MHz system clock; timeouts are counted in that clock.
package pcsd_pkg;

  localparam int unsigned PCSD_CLK_MHZ = 100;
  // Timeouts in nanoseconds, as printed (typical and longest)
  localparam int unsigned PCSD_TIMEOUT_TYP_NS = 2600;
  localparam int unsigned PCSD_TIMEOUT_MAX_NS = 4000;
  localparam int unsigned PCSD_CLK_PERIOD_NS = 1000 / PCSD_CLK_MHZ;
  // Use the typical figure; it is below the longest so rounding down is safe
  localparam int unsigned PCSD_LATCH_CYCLES = PCSD_TIMEOUT_TYP_NS / PCSD_CLK_PERIOD_NS;
  localparam int unsigned PCSD_OFF_CYCLES = PCSD_TIMEOUT_TYP_NS / PCSD_CLK_PERIOD_NS;
  localparam int unsigned PCSD_TMR_W = 12;
  localparam logic [PCSD_TMR_W-1:0] PCSD_LATCH_LAST =
    PCSD_TMR_W'(PCSD_LATCH_CYCLES - 1);
  localparam logic [PCSD_TMR_W-1:0] PCSD_OFF_LAST = PCSD_TMR_W'(PCSD_OFF_CYCLES - 1);

  // Switch counts of the two variants
  localparam int unsigned PCSD_SW_MAX = 5;
  localparam int unsigned PCSD_SW_SMALL = 3;
  localparam logic [4:0] PCSD_CNT_RESET = 5'h00;
  localparam logic [4:0] PCSD_SW_RESET = 5'h00;

  // Gray-coded along disabled -> counting -> latched
  typedef enum logic [1:0] {
    PCSD_ST_OFF = 2'b00,
    PCSD_ST_COUNT = 2'b01,
    PCSD_ST_HOLD = 2'b11
  } pcsd_state_t;

endpackage : pcsd_pkg

// ==== core/pcsd_sync.sv ====
// Two-flop synchroniser for one asynchronous level.
// Assumes a single clock domain; output is the second stage only.
module pcsd_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Level
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : pcsd_sync

// ==== core/pcsd_timer.sv ====
// Level-duration timer: counts cycles while a level holds, flags at the limit.
// Assumes the limit is a constant below two to the width.
module pcsd_timer
  import pcsd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_run,
  input wire logic [PCSD_TMR_W-1:0] i_last,
  output logic o_done
);
  logic [PCSD_TMR_W-1:0] cnt_r;

  // Done is sticky while the level holds, cleared on the first clock after it drops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= '0;
      o_done <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= '0;
      o_done <= 1'b0;
    end else if (cnt_r == i_last) begin
      o_done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + PCSD_TMR_W'(1);
    end
  end
endmodule : pcsd_timer

// ==== core/pcsd_top.sv ====
// Pulse-count switch decoder: single control line drives five (or three) switches.
// Assumes the control line is asynchronous and the supply-good flag is a level.
//
// Function
// RQ1: Every rising edge on the control line advances the control counter by one.
// RQ2: In the five-switch variant the count decodes into 32 distinct switch patterns.
// RQ3: In the five-switch variant the counter wraps to its first state after 32 edges.
// RQ4: The host keeps pulse bursts at or below 1 MHz.
// RQ5: The count reaches the outputs only after the line stays high for the latch timeout.
// RQ6: When disabled, the first rising edge enables the device and counts as the first edge.
// RQ7: Further low pulses change the state, applied after the line stays high for the timeout.
// RQ8: The device disables itself after the line stays low for the off timeout.
// RQ9: In the three-switch variant the count decodes into eight patterns and wraps after eight.
// RQ10: A supply below the operating level forces every switch off.
// RQ11: Each of the five switch outputs is controlled on its own from the decoded count.
// RQ12: Count one turns all on; count minus one is the off mask with output one as bit zero.
// RQ13: A new burst after a latched state restarts the counter from zero.
// RQ14: The host keeps low phases below the off timeout and gaps below the latch timeout.
module pcsd_top
  import pcsd_pkg::*;
#(
  // Set to 1 for the three-switch variant
  parameter bit SMALL_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control line and supply monitor
  input wire logic i_serial_enable,
  input wire logic i_supply_ok,
  // Switch outputs, bit 0 is switch_output_one, bit 4 switch_output_five
  output logic [4:0] o_switch_on,
  output logic o_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic line_s;
  logic supply_s;
  logic line_d_r;
  logic rise;
  logic fall;

  pcsd_sync u_sync_line (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_serial_enable),
    .o_sync(line_s)
  );

  pcsd_sync u_sync_supply (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_supply_ok),
    .o_sync(supply_s)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      line_d_r <= 1'b0;
    end else begin
      line_d_r <= line_s;
    end
  end

  assign rise = line_s && !line_d_r;
  assign fall = !line_s && line_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timeouts

  logic latch_done;
  logic off_done;
  logic latch_done_d_r;
  logic latch_evt;

  pcsd_timer u_latch_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(line_s),
    .i_last(PCSD_LATCH_LAST),
    .o_done(latch_done)
  );

  pcsd_timer u_off_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(!line_s),
    .i_last(PCSD_OFF_LAST),
    .o_done(off_done)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_done_d_r <= 1'b0;
    end else begin
      latch_done_d_r <= latch_done;
    end
  end

  assign latch_evt = latch_done && !latch_done_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  pcsd_state_t state_r;
  pcsd_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCSD_ST_OFF: begin
        if (rise && supply_s) begin
          state_nxt = PCSD_ST_COUNT; // [RQ6]
        end
      end
      PCSD_ST_COUNT: begin
        if (latch_evt) begin
          state_nxt = PCSD_ST_HOLD; // [RQ5]
        end
      end
      PCSD_ST_HOLD: begin
        if (rise) begin
          state_nxt = PCSD_ST_COUNT; // [RQ7]
        end
      end
      default: begin
        state_nxt = PCSD_ST_OFF;
      end
    endcase
    // A rise ends the low phase, so it beats an off flag still set from it
    if ((off_done && !rise) || !supply_s) begin
      state_nxt = PCSD_ST_OFF; // [RQ8] [RQ10]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= PCSD_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge counter

  // Holds count minus one, so it is directly the off mask
  logic [4:0] cnt_r;
  logic [4:0] cnt_mask;

  assign cnt_mask = SMALL_VARIANT ? 5'h07 : 5'h1F; // [RQ3] [RQ9]

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= PCSD_CNT_RESET;
    end else if (rise && state_r != PCSD_ST_COUNT) begin
      cnt_r <= PCSD_CNT_RESET; // [RQ6] [RQ13]
    end else if (rise) begin
      cnt_r <= (cnt_r + 5'h01) & cnt_mask; // [RQ1] [RQ3] [RQ9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Switches only follow the latched count, never the running one
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_switch_on <= PCSD_SW_RESET;
    end else if (state_nxt == PCSD_ST_OFF) begin
      o_switch_on <= PCSD_SW_RESET; // [RQ8] [RQ10]
    end else if (state_r == PCSD_ST_COUNT && latch_evt) begin
      o_switch_on <= ~cnt_r & cnt_mask; // [RQ2] [RQ11] [RQ12] [RQ5]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_enabled <= 1'b0;
    end else begin
      o_enabled <= state_nxt != PCSD_ST_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_held_off;
    !line_s [*8];
  endsequence

  property p_count_step;
    @(posedge i_clk) disable iff (!i_arst_n)
      (rise && state_r == PCSD_ST_COUNT && !off_done && supply_s)
      |=> cnt_r == (($past(cnt_r) + 5'h01) & cnt_mask);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step"); // [RQ1]

  property p_wrap;
    @(posedge i_clk) disable iff (!i_arst_n) cnt_r <= cnt_mask;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count beyond wrap"); // [RQ3]

  property p_first_edge;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_r == PCSD_ST_OFF && rise && supply_s) |=> (cnt_r == 5'h00 && o_enabled);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first edge wrong"); // [RQ6]

  property p_restart;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_r == PCSD_ST_HOLD && rise) |=> cnt_r == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // [RQ13]

  property p_latch_time;
    @(posedge i_clk) disable iff (!i_arst_n)
      $changed(o_switch_on) && o_enabled |-> $past(line_s) && latch_done;
  endproperty
  a_latch_time: assert property (p_latch_time) else $error("early latch"); // [RQ5] [RQ7]

  property p_decode;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_r == PCSD_ST_COUNT && latch_evt && supply_s)
      |=> o_switch_on == (~$past(cnt_r) & cnt_mask);
  endproperty
  a_decode: assert property (p_decode) else $error("decode mismatch"); // [RQ12]

  property p_off_timeout;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_held_off ##0 off_done |=> (o_switch_on == 5'h00 && !o_enabled);
  endproperty
  a_off_timeout: assert property (p_off_timeout) else $error("no off timeout"); // [RQ8]

  property p_uvlo;
    @(posedge i_clk) disable iff (!i_arst_n)
      !supply_s |=> (o_switch_on == 5'h00 && !o_enabled);
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("switch on under low supply"); // [RQ10]

  property p_small;
    @(posedge i_clk) disable iff (!i_arst_n)
      SMALL_VARIANT |-> o_switch_on[4:3] == 2'b00;
  endproperty
  a_small: assert property (p_small) else $error("small variant upper bits"); // [RQ9]

  // Own run-length counters, so the timers' counts are not taken on trust
  logic [PCSD_TMR_W-1:0] high_run_r;
  logic [PCSD_TMR_W-1:0] low_run_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      high_run_r <= '0;
    end else if (!line_s) begin
      high_run_r <= '0;
    end else if (high_run_r != '1) begin
      high_run_r <= high_run_r + PCSD_TMR_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_run_r <= '0;
    end else if (line_s) begin
      low_run_r <= '0;
    end else if (low_run_r != '1) begin
      low_run_r <= low_run_r + PCSD_TMR_W'(1);
    end
  end

  property p_lat_run;
    @(posedge i_clk) disable iff (!i_arst_n)
      latch_evt |-> high_run_r == PCSD_TMR_W'(PCSD_LATCH_CYCLES);
  endproperty
  a_lat_run: assert property (p_lat_run) else $error("latch not at timeout"); // [RQ5]

  property p_off_run;
    @(posedge i_clk) disable iff (!i_arst_n)
      $rose(off_done) |-> low_run_r == PCSD_TMR_W'(PCSD_OFF_CYCLES);
  endproperty
  a_off_run: assert property (p_off_run) else $error("off not at timeout"); // [RQ8]

  property p_hold_sw;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_nxt != PCSD_ST_OFF && !(state_r == PCSD_ST_COUNT && latch_evt))
      |=> $stable(o_switch_on);
  endproperty
  a_hold_sw: assert property (p_hold_sw) else $error("switches moved between latches"); // [RQ7]

  property p_stay_off;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_r == PCSD_ST_OFF && !(rise && supply_s))
      |=> (!o_enabled && o_switch_on == 5'h00);
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("woke without an edge"); // [RQ6]

  sequence s_last_edge;
    state_r == PCSD_ST_COUNT && rise && cnt_r == cnt_mask && !off_done && supply_s;
  endsequence

  property p_wrap_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_last_edge |=> cnt_r == 5'h00;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero"); // [RQ3] [RQ9]

endmodule : pcsd_top

// ==== tb/pcsd_host_model.sv ====
// Host-side model of the control line: counted bursts of low-going pulses.
// Assumes the bench clock at 100 MHz; the line is always driven, no pull.
module pcsd_host_model (
  // Clock
  input wire logic i_clk,
  // Control line to the device
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half of a 1 us pulse period, so bursts never exceed 1 MHz
  localparam int HALF = 50;
  initial o_line = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Low and high phases well inside both timeouts keep one burst as one group
  task automatic send_burst(input int n);
    repeat (n) begin
      @(posedge i_clk) o_line <= 1'b0;
      repeat (HALF - 1) @(posedge i_clk);
      @(posedge i_clk) o_line <= 1'b1;
      repeat (HALF - 1) @(posedge i_clk);
    end
  endtask : send_burst
  task automatic hold_low(input int cycles);
    @(posedge i_clk) o_line <= 1'b0;
    repeat (cycles - 1) @(posedge i_clk);
  endtask : hold_low
endmodule : pcsd_host_model

// ==== tb/tb_top.sv ====
// Bench top: one host model drives the five- and three-switch variants.
// Assumes the design under core/; clock and reset are made here.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk;
  logic i_arst_n;
  logic i_supply_ok;
  logic line;
  logic [4:0] sw_big;
  logic [4:0] sw_small;
  logic en_big;
  logic en_small;
  logic [4:0] prev_big;
  logic [4:0] prev_small;
  int failures;
  int n_compared;
  int counts[7] = '{2, 16, 17, 32, 33, 8, 9};

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  pcsd_host_model host (.i_clk(i_clk), .o_line(line));
  pcsd_top #(.SMALL_VARIANT(1'b0)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_serial_enable(line), .i_supply_ok(i_supply_ok), .o_switch_on(sw_big),
    .o_enabled(en_big));
  pcsd_top #(.SMALL_VARIANT(1'b1)) dut_small (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_serial_enable(line), .i_supply_ok(i_supply_ok), .o_switch_on(sw_small),
    .o_enabled(en_small));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic settle(input int cycles);
    repeat (cycles) @(posedge i_clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Old state must hold until the latch timeout, then the decoded count shows
  task automatic t_burst(input int n);
    logic [4:0] eb;
    logic [4:0] es;
    eb = ~5'((n - 1) % 32);
    es = {2'b00, ~3'((n - 1) % 8)};
    host.send_burst(n);
    settle(200);
    check({en_big, sw_big}, {1'b1, prev_big});
    check({en_small, sw_small}, {1'b1, prev_small});
    settle(100);
    check({en_big, sw_big}, {1'b1, eb});
    check({en_small, sw_small}, {1'b1, es});
    prev_big = eb;
    prev_small = es;
  endtask : t_burst

  task automatic t_off();
    host.hold_low(250);
    #1;
    check({en_big, sw_big}, {1'b1, prev_big});
    settle(30);
    check({en_big, sw_big}, 6'h00);
    check({en_small, sw_small}, 6'h00);
    prev_big = 5'h00;
    prev_small = 5'h00;
  endtask : t_off

  // Edges during undervoltage must not wake the device
  task automatic t_uvlo();
    @(posedge i_clk) i_supply_ok <= 1'b0;
    settle(6);
    check({en_big, sw_big}, 6'h00);
    check({en_small, sw_small}, 6'h00);
    host.send_burst(2);
    settle(300);
    check({en_big, sw_big}, 6'h00);
    check({en_small, sw_small}, 6'h00);
    prev_big = 5'h00;
    prev_small = 5'h00;
    @(posedge i_clk) i_supply_ok <= 1'b1;
  endtask : t_uvlo

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0;
    i_supply_ok = 1'b1;
    prev_big = 5'h00;
    prev_small = 5'h00;
    failures = 0;
    n_compared = 0;
    repeat (15) @(posedge i_clk);
    @(posedge i_clk) i_arst_n <= 1'b1;
    settle(1);
    check({en_big, sw_big}, 6'h00);
    check({en_small, sw_small}, 6'h00);
    t_burst(1);
    foreach (counts[i]) begin
      t_burst(counts[i]);
    end
    t_off();
    t_burst(3);
    t_uvlo();
    t_burst(4);
    summarize();
  end

  // Whole run needs about 16300 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    failures++;
    summarize();
  end
endmodule : tb_top
